// file: rtl/plb_phy.sv
/*
 Device end: loopback control of the PHY digital core. Holds the
 management registers, decodes speed and duplex, and steers the
 MAC and line streams for near and far loopback, and flags connector loopback.
 Assumes the line side logic runs on clock_in and that the manager
 keeps its programming sequences.
*/
// Chosen here: register access over the request/ack management bus and the register offsets.
`timescale 1ns/10ps
`include "plb_map.svh"
module plb_phy import plb_pkg::*; #(
	parameter logic [3:0] RXC_HALF = `PLB_RXC_HALF
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic arst_n_in,
	// Manager and MAC side
	plb_if.phy bus,
	// Line receive stream from the copper core
	input wire logic [7:0] line_rxd_in,
	input wire logic line_rx_dv_in,
	input wire logic line_rx_er_in,
	// Auto-negotiation result from the copper core
	input wire logic an_done_in,
	input wire logic [1:0] an_speed_in,
	input wire logic an_full_in,
	// Line transmit stream to the copper core
	output logic [7:0] line_txd_out,
	output logic line_tx_en_out,
	output logic line_tx_er_out,
	// Effective configuration
	output logic [1:0] speed_out,
	output logic full_duplex_out,
	output logic an_enable_out,
	output logic role_master_out,
	// Active loopback path
	output logic near_active_out,
	output logic far_active_out,
	output logic ext_active_out
);
	localparam int MMD_N = 4;
	localparam logic [4:0] MMD_ADDR [MMD_N] = '{`PLB_MMD_R0, `PLB_MMD_R1,
		`PLB_MMD_R2, `PLB_MMD_R3};

	logic [15:0] bc_ff; // Basic control
	logic [15:0] adv_ff; // Advertisement
	logic [15:0] msc_ff; // Master/slave control
	logic [15:0] rlb_ff; // Remote loopback
	logic [15:0] xlb_ff; // External loopback
	logic [15:0] mmd_ff [MMD_N]; // Vendor tuning words
	logic ack_ff; // Answer to a request
	logic [15:0] rdata_ff; // Read answer
	logic [15:0] nxt_rdata;
	logic take; // Request taken this cycle
	logic wr_std; // Write to a standard register
	logic [3:0] rxc_cnt_ff; // Receive clock divider
	logic rxc_ff; // Receive clock level
	logic [4:0] rxc_dly_ff; // Receive clock history
	logic txc_s1_ff; // Transmit clock sync stages
	logic txc_s2_ff;
	logic txc_s3_ff;
	logic txc_filt_ff; // Filtered transmit clock
	logic txc_ok_ff; // Transmit clock follows receive clock
	logic [1:0] eff_speed; // Effective speed code
	logic eff_fd; // Effective full duplex
	logic link_ok; // Link usable
	logic near_act;
	logic far_act;
	logic ext_act;
	logic [7:0] mask; // Lane mask, nibble in MII
	logic [7:0] mrxd_ff;
	logic mrxdv_ff;
	logic mrxer_ff;
	logic [7:0] ltxd_ff;
	logic ltxen_ff;
	logic ltxer_ff;

	// One request at a time; the ack cycle never takes a new one
	assign take = bus.mg_req & ~ack_ff;
	assign wr_std = take & bus.mg_we & ~bus.mg_mmd;

	// Answer one cycle after the request is seen
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ack_ff <= 1'b0;
			rdata_ff <= `PLB_ZERO16;
		end else begin
			ack_ff <= take;
			if (take) begin
				rdata_ff <= nxt_rdata;
			end
		end
	end

	// Standard register writes
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			bc_ff <= `PLB_BC_RST;
			adv_ff <= `PLB_ADV_RST;
			msc_ff <= `PLB_MSC_RST;
			rlb_ff <= `PLB_ZERO16;
			xlb_ff <= `PLB_ZERO16;
		end else if (wr_std) begin
			unique case (bus.mg_addr)
				`PLB_REG_BC: begin
					bc_ff <= bus.mg_wdata;
				end
				`PLB_REG_ADV: begin
					adv_ff <= bus.mg_wdata;
				end
				`PLB_REG_MSC: begin
					msc_ff <= bus.mg_wdata;
				end
				`PLB_REG_RLB: begin
					rlb_ff <= bus.mg_wdata;
				end
				`PLB_REG_XLB: begin
					xlb_ff <= bus.mg_wdata;
				end
				default: begin
					// Unknown address: write ignored
				end
			endcase
		end
	end

	// Vendor MMD tuning words, one per entry
	genvar gi;
	generate
		for (gi = 0; gi < MMD_N; gi++) begin : g_mmd
			always_ff @(posedge clock_in or negedge arst_n_in) begin
				if (!arst_n_in) begin
					mmd_ff[gi] <= `PLB_ZERO16;
				end else if (take && bus.mg_we && bus.mg_mmd &&
					bus.mg_dev == `PLB_MMD_DEV &&
					bus.mg_addr == MMD_ADDR[gi]) begin
					mmd_ff[gi] <= bus.mg_wdata;
				end
			end
		end
	endgenerate

	// Read multiplexer; unknown addresses read zero
	always_comb begin
		nxt_rdata = `PLB_ZERO16;
		if (bus.mg_mmd) begin
			for (int i = 0; i < MMD_N; i++) begin
				if (bus.mg_dev == `PLB_MMD_DEV &&
					bus.mg_addr == MMD_ADDR[i]) begin
					nxt_rdata = mmd_ff[i];
				end
			end
		end else begin
			unique case (bus.mg_addr)
				`PLB_REG_BC: nxt_rdata = bc_ff;
				`PLB_REG_ADV: nxt_rdata = adv_ff;
				`PLB_REG_MSC: nxt_rdata = msc_ff;
				`PLB_REG_RLB: nxt_rdata = rlb_ff;
				`PLB_REG_XLB: nxt_rdata = xlb_ff;
				default: nxt_rdata = `PLB_ZERO16;
			endcase
		end
	end

	// Effective speed and duplex. With AN off the forced bits rule;
	// in connector loopback the partner is ourselves, so the best
	// common ability is our own advertisement.
	always_comb begin
		eff_speed = {bc_ff[`PLB_BC_SPD_MSB], bc_ff[`PLB_BC_SPD_LSB]};
		eff_fd = bc_ff[`PLB_BC_FD];
		link_ok = 1'b1;
		if (bc_ff[`PLB_BC_AN]) begin
			if (xlb_ff[`PLB_XLB_EN]) begin
				eff_fd = 1'b1;
				if (msc_ff[`PLB_MSC_1000FD]) begin
					eff_speed = PLB_SPD_1000;
				end else if (adv_ff[`PLB_ADV_100FD]) begin
					eff_speed = PLB_SPD_100;
				end else begin
					eff_speed = PLB_SPD_10;
					eff_fd = adv_ff[`PLB_ADV_10FD];
				end
			end else begin
				eff_speed = an_speed_in;
				eff_fd = an_full_in;
				link_ok = an_done_in;
			end
		end
	end

	// Path selection; near wins over far, far over connector
	assign near_act = bc_ff[`PLB_BC_LOOP] & eff_fd;
	assign far_act = rlb_ff[`PLB_RLB_EN] & ~near_act & eff_fd & link_ok &
		(eff_speed == PLB_SPD_1000) & txc_ok_ff;
	assign ext_act = xlb_ff[`PLB_XLB_EN] & ~near_act & ~far_act;
	// MII carries only the low nibble
	assign mask = (eff_speed == PLB_SPD_1000) ? `PLB_MASK_GMII :
		`PLB_MASK_MII;

	// Receive clock toward the MAC, a divided system clock
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rxc_cnt_ff <= 4'h0;
			rxc_ff <= 1'b0;
			rxc_dly_ff <= 5'h00;
		end else begin
			rxc_dly_ff <= {rxc_dly_ff[3:0], rxc_ff};
			if (rxc_cnt_ff >= RXC_HALF - 4'h1) begin
				rxc_cnt_ff <= 4'h0;
				rxc_ff <= ~rxc_ff;
			end else begin
				rxc_cnt_ff <= rxc_cnt_ff + 4'h1;
			end
		end
	end

	// Transmit clock arrives from outside: three stages, a change
	// counts once the last two agree. Far loopback stays off unless
	// it tracks our receive clock, since a missing feedback would
	// otherwise return frames on a dead clock.
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			txc_s1_ff <= 1'b0;
			txc_s2_ff <= 1'b0;
			txc_s3_ff <= 1'b0;
			txc_filt_ff <= 1'b0;
			txc_ok_ff <= 1'b0;
		end else begin
			txc_s1_ff <= bus.tx_clk;
			txc_s2_ff <= txc_s1_ff;
			txc_s3_ff <= txc_s2_ff;
			if (txc_s2_ff == txc_s3_ff) begin
				txc_filt_ff <= txc_s3_ff;
			end
			txc_ok_ff <= (txc_filt_ff == rxc_dly_ff[3]) |
				(txc_filt_ff == rxc_dly_ff[4]);
		end
	end

	// Stream toward the MAC
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			mrxd_ff <= `PLB_IDLE;
			mrxdv_ff <= 1'b0;
			mrxer_ff <= 1'b0;
		end else if (near_act) begin
			mrxd_ff <= bus.mac_txd & mask;
			mrxdv_ff <= bus.mac_tx_en;
			mrxer_ff <= bus.mac_tx_er;
		end else begin
			mrxd_ff <= line_rxd_in & mask;
			mrxdv_ff <= line_rx_dv_in;
			mrxer_ff <= line_rx_er_in;
		end
	end

	// Stream toward the line; idle while frames loop back inside
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ltxd_ff <= `PLB_IDLE;
			ltxen_ff <= 1'b0;
			ltxer_ff <= 1'b0;
		end else if (far_act) begin
			ltxd_ff <= line_rxd_in;
			ltxen_ff <= line_rx_dv_in;
			ltxer_ff <= line_rx_er_in;
		end else if (near_act) begin
			ltxd_ff <= `PLB_IDLE;
			ltxen_ff <= 1'b0;
			ltxer_ff <= 1'b0;
		end else begin
			ltxd_ff <= bus.mac_txd & mask;
			ltxen_ff <= bus.mac_tx_en;
			ltxer_ff <= bus.mac_tx_er;
		end
	end

	// Outputs
	assign bus.mg_ack = ack_ff;
	assign bus.mg_rdata = rdata_ff;
	assign bus.mac_rxd = mrxd_ff;
	assign bus.mac_rx_dv = mrxdv_ff;
	assign bus.mac_rx_er = mrxer_ff;
	assign bus.rx_clk = rxc_ff;
	assign line_txd_out = ltxd_ff;
	assign line_tx_en_out = ltxen_ff;
	assign line_tx_er_out = ltxer_ff;
	assign speed_out = eff_speed;
	assign full_duplex_out = eff_fd;
	assign an_enable_out = bc_ff[`PLB_BC_AN];
	// Manual setting picks the role; otherwise slave by default
	assign role_master_out = msc_ff[`PLB_MSC_MAN] & msc_ff[`PLB_MSC_VAL];
	assign near_active_out = near_act;
	assign far_active_out = far_act;
	assign ext_active_out = ext_act;
endmodule

// file: rtl/plb_map.svh
/*
 Register addresses, bit positions, reset values and command words
 for the loopback control pair. Included by both ends.
*/
`ifndef PLB_MAP_SVH
`define PLB_MAP_SVH
// Management register addresses on the device
`define PLB_REG_BC 5'h00
`define PLB_REG_ADV 5'h04
`define PLB_REG_MSC 5'h09
`define PLB_REG_RLB 5'h11
`define PLB_REG_XLB 5'h12
// Basic control bit positions
`define PLB_BC_LOOP 14
`define PLB_BC_SPD_LSB 13
`define PLB_BC_AN 12
`define PLB_BC_FD 8
`define PLB_BC_SPD_MSB 6
// Advertisement and master/slave control bits
`define PLB_ADV_100FD 8
`define PLB_ADV_10FD 6
`define PLB_MSC_MAN 12
`define PLB_MSC_VAL 11
`define PLB_MSC_1000FD 9
// Loopback enable bits
`define PLB_RLB_EN 8
`define PLB_XLB_EN 0
// Reset values
`define PLB_BC_RST 16'h1140
`define PLB_ADV_RST 16'h01E1
`define PLB_MSC_RST 16'h0200
`define PLB_ZERO16 16'h0000
// Vendor MMD device and its tuning registers
`define PLB_MMD_DEV 5'h1C
`define PLB_MMD_R0 5'h15
`define PLB_MMD_R1 5'h16
`define PLB_MMD_R2 5'h18
`define PLB_MMD_R3 5'h1B
`define PLB_MMD_LOOP 16'hEEEE
// Command words written by the manager
`define PLB_BC_NEAR 16'h4000
`define PLB_BC_G1000 16'h0140
`define PLB_MSC_SLAVE 16'h1000
`define PLB_MSC_MASTER 16'h1800
`define PLB_RLB_ON 16'h0100
`define PLB_XLB_ON 16'h0001
// Data lane masks
`define PLB_MASK_GMII 8'hFF
`define PLB_MASK_MII 8'h0F
`define PLB_IDLE 8'h00
// Receive clock half period in system cycles
`define PLB_RXC_HALF 4'h2
// Manager APB map
`define PLB_APB_CTRL 12'h000
`define PLB_APB_STAT 12'h004
`define PLB_CTRL_GO 8
`define PLB_CTRL_AN 4
`endif

// file: rtl/plb_pkg.sv
/*
 Types shared by the device end and the manager end.
 Assumes plb_map.svh supplies the numeric constants.
*/
package plb_pkg;
	// Speed code as formed by basic control bits {6, 13}
	typedef enum logic [1:0] {
		PLB_SPD_10 = 2'b00,
		PLB_SPD_100 = 2'b01,
		PLB_SPD_1000 = 2'b10
	} plb_speed_e;
	// Loopback mode requested by software
	typedef enum logic [1:0] {
		PLB_MODE_NONE = 2'b00,
		PLB_MODE_NEAR = 2'b01,
		PLB_MODE_FAR = 2'b10,
		PLB_MODE_EXT = 2'b11
	} plb_mode_e;
	// Manager sequencer states, Gray along the path
	typedef enum logic [1:0] {
		PLB_ST_IDLE = 2'b00,
		PLB_ST_ISSUE = 2'b01,
		PLB_ST_DONE = 2'b11
	} plb_state_e;
	// One management write
	typedef struct packed {
		logic last;
		logic mmd;
		logic [4:0] dev;
		logic [4:0] addr;
		logic [15:0] data;
	} plb_cmd_s;
endpackage

// file: rtl/plb_if.sv
/*
 Carrier between the device end and the manager end: management
 access plus the GMII/MII stream and its clocks as sampled levels.
 Assumes both ends run on the same system clock.
*/
`timescale 1ns/10ps
interface plb_if;
	// Management access
	logic mg_req; // Request held until ack
	logic mg_we; // Write when high
	logic mg_mmd; // Access targets an MMD device
	logic [4:0] mg_dev; // MMD device
	logic [4:0] mg_addr; // Register address
	logic [15:0] mg_wdata; // Write data
	logic mg_ack; // One-cycle answer
	logic [15:0] mg_rdata; // Read data, valid with ack
	// MAC transmit path into the device
	logic [7:0] mac_txd;
	logic mac_tx_en;
	logic mac_tx_er;
	// Device receive path to the MAC
	logic [7:0] mac_rxd;
	logic mac_rx_dv;
	logic mac_rx_er;
	// Clock levels
	logic rx_clk; // From device
	logic tx_clk; // From MAC side
	modport phy (input mg_req, mg_we, mg_mmd, mg_dev, mg_addr, mg_wdata,
		input mac_txd, mac_tx_en, mac_tx_er, tx_clk,
		output mg_ack, mg_rdata, mac_rxd, mac_rx_dv, mac_rx_er, rx_clk);
	modport mgr (output mg_req, mg_we, mg_mmd, mg_dev, mg_addr, mg_wdata,
		output mac_txd, mac_tx_en, mac_tx_er, tx_clk,
		input mg_ack, mg_rdata, mac_rxd, mac_rx_dv, mac_rx_er, rx_clk);
endinterface

// file: rtl/plb_mgr.sv
/*
 Manager end: APB slave for software, a sequencer that programs the
 device for the chosen loopback mode, and the MAC stream side.
 Assumes the device answers each request with a one-cycle ack.
*/
`timescale 1ns/10ps
`include "plb_map.svh"
module plb_mgr import plb_pkg::*; (
	// Clock and reset
	input wire logic clock_in,
	input wire logic arst_n_in,
	// APB slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// MAC user stream
	input wire logic [7:0] user_txd_in,
	input wire logic user_tx_en_in,
	input wire logic user_tx_er_in,
	output logic [7:0] user_rxd_out,
	output logic user_rx_dv_out,
	output logic user_rx_er_out,
	// Device side
	plb_if.mgr bus
);
	logic [4:0] ctrl_ff; // {use_an, speed, mode}
	logic done_ff; // Sequence finished, sticky
	logic [2:0] idx_ff; // Step within the sequence
	plb_state_e st_ff;
	plb_cmd_s cmd;
	logic [31:0] prdata_ff;
	logic apb_wr; // Write takes effect
	logic go; // Start request
	logic mapped;
	logic own_txc_ff; // Local transmit clock
	logic [7:0] txd_ff;
	logic txen_ff;
	logic txer_ff;
	logic [7:0] rxd_ff;
	logic rxdv_ff;
	logic rxer_ff;

	// Write sequence for a mode. The last step carries the flag.
	function automatic plb_cmd_s step_f(input logic [4:0] c,
		input logic [2:0] i);
		plb_cmd_s r;
		logic [15:0] bcv;
		logic g;
		r = '0;
		bcv = `PLB_ZERO16;
		bcv[`PLB_BC_SPD_MSB] = c[3];
		bcv[`PLB_BC_SPD_LSB] = c[2];
		bcv[`PLB_BC_FD] = 1'b1;
		g = (c[3:2] == PLB_SPD_1000);
		unique case (plb_mode_e'(c[1:0]))
			PLB_MODE_NEAR: begin
				if (i < 3'h4) begin
					r.mmd = 1'b1;
					r.dev = `PLB_MMD_DEV;
					r.data = `PLB_MMD_LOOP;
					unique case (i[1:0])
						2'h0: r.addr = `PLB_MMD_R0;
						2'h1: r.addr = `PLB_MMD_R1;
						2'h2: r.addr = `PLB_MMD_R2;
						2'h3: r.addr = `PLB_MMD_R3;
					endcase
				end else if (i == 3'h4) begin
					r.addr = `PLB_REG_BC;
					r.data = `PLB_BC_NEAR | bcv;
					r.last = ~g;
				end else begin
					r.addr = `PLB_REG_MSC;
					r.data = `PLB_MSC_SLAVE;
					r.last = 1'b1;
				end
			end
			PLB_MODE_FAR: begin
				if (c[`PLB_CTRL_AN] || i != 3'h0) begin
					r.addr = `PLB_REG_RLB;
					r.data = `PLB_RLB_ON;
					r.last = 1'b1;
				end else begin
					r.addr = `PLB_REG_BC;
					r.data = `PLB_BC_G1000;
				end
			end
			PLB_MODE_EXT: begin
				if (i == 3'h0) begin
					r.addr = `PLB_REG_BC;
					r.data = g ? `PLB_BC_G1000 : bcv;
				end else if (i == 3'h1 && g) begin
					r.addr = `PLB_REG_MSC;
					r.data = `PLB_MSC_MASTER;
				end else begin
					r.addr = `PLB_REG_XLB;
					r.data = `PLB_XLB_ON;
					r.last = 1'b1;
				end
			end
			PLB_MODE_NONE: begin
				// Leave every loopback and restore the basic control reset value
				r.addr = (i == 3'h0) ? `PLB_REG_RLB :
					(i == 3'h1) ? `PLB_REG_XLB : `PLB_REG_BC;
				r.data = (i >= 3'h2) ? `PLB_BC_RST : `PLB_ZERO16;
				r.last = (i >= 3'h2);
			end
		endcase
		return r;
	endfunction

	assign apb_wr = psel_in & penable_in & pwrite_in;
	assign go = apb_wr & (paddr_in == `PLB_APB_CTRL) &
		pwdata_in[`PLB_CTRL_GO] & (st_ff != PLB_ST_ISSUE);
	assign mapped = (paddr_in == `PLB_APB_CTRL) |
		(paddr_in == `PLB_APB_STAT);
	assign cmd = step_f(ctrl_ff, idx_ff);

	// Control register; frozen while a sequence runs
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ctrl_ff <= 5'h00;
		end else if (apb_wr && paddr_in == `PLB_APB_CTRL &&
			st_ff != PLB_ST_ISSUE) begin
			ctrl_ff <= pwdata_in[4:0];
		end
	end

	// Sequencer: hold each request until the device acks it
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st_ff <= PLB_ST_IDLE;
			idx_ff <= 3'h0;
		end else begin
			unique case (st_ff)
				PLB_ST_IDLE, PLB_ST_DONE: begin
					if (go) begin
						st_ff <= PLB_ST_ISSUE;
						idx_ff <= 3'h0;
					end
				end
				PLB_ST_ISSUE: begin
					if (bus.mg_ack) begin
						if (cmd.last) begin
							st_ff <= PLB_ST_DONE;
						end else begin
							idx_ff <= idx_ff + 3'h1;
						end
					end
				end
				default: begin
					st_ff <= PLB_ST_IDLE;
				end
			endcase
		end
	end

	// Done flag: finishing wins over a clearing start
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			done_ff <= 1'b0;
		end else if (st_ff == PLB_ST_ISSUE && bus.mg_ack && cmd.last) begin
			done_ff <= 1'b1;
		end else if (go) begin
			done_ff <= 1'b0;
		end
	end

	// Read data latched in the setup cycle
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			prdata_ff <= 32'h0000_0000;
		end else if (psel_in && !penable_in) begin
			prdata_ff <= 32'h0000_0000;
			if (paddr_in == `PLB_APB_CTRL) begin
				prdata_ff[4:0] <= ctrl_ff;
			end else if (paddr_in == `PLB_APB_STAT) begin
				prdata_ff[2:0] <= {done_ff, st_ff == PLB_ST_ISSUE,
					st_ff == PLB_ST_ISSUE};
				prdata_ff[10:8] <= idx_ff;
			end
		end
	end

	// MAC streams, one register stage each way; local clock toggles
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			own_txc_ff <= 1'b0;
			txd_ff <= `PLB_IDLE;
			txen_ff <= 1'b0;
			txer_ff <= 1'b0;
			rxd_ff <= `PLB_IDLE;
			rxdv_ff <= 1'b0;
			rxer_ff <= 1'b0;
		end else begin
			own_txc_ff <= ~own_txc_ff;
			txd_ff <= user_txd_in;
			txen_ff <= user_tx_en_in;
			txer_ff <= user_tx_er_in;
			rxd_ff <= bus.mac_rxd;
			rxdv_ff <= bus.mac_rx_dv;
			rxer_ff <= bus.mac_rx_er;
		end
	end

	// Device outputs
	assign bus.mg_req = (st_ff == PLB_ST_ISSUE);
	assign bus.mg_we = 1'b1;
	assign bus.mg_mmd = cmd.mmd;
	assign bus.mg_dev = cmd.dev;
	assign bus.mg_addr = cmd.addr;
	assign bus.mg_wdata = cmd.data;
	assign bus.mac_txd = txd_ff;
	assign bus.mac_tx_en = txen_ff;
	assign bus.mac_tx_er = txer_ff;
	// Far loopback: receive clock returned as transmit clock
	assign bus.tx_clk = (ctrl_ff[1:0] == PLB_MODE_FAR) ? bus.rx_clk :
		own_txc_ff;
	// APB answers
	assign pready_out = 1'b1;
	assign pslverr_out = psel_in & penable_in & ~mapped;
	assign prdata_out = prdata_ff;
	assign user_rxd_out = rxd_ff;
	assign user_rx_dv_out = rxdv_ff;
	assign user_rx_er_out = rxer_ff;
endmodule

// file: test/plb_loop_asserts.sv
/*
 Checker for the loopback pair: management handshake, command words
 and the near loop stream on the carrier.
 Assumes one clock and reset shared by both ends.
*/
`timescale 1ns/10ps
`include "plb_map.svh"
module plb_loop_asserts #(
	parameter logic [3:0] RXC_HALF = `PLB_RXC_HALF
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic arst_n_in,
	// Management access
	input wire logic mg_req,
	input wire logic mg_we,
	input wire logic mg_mmd,
	input wire logic [4:0] mg_dev,
	input wire logic [4:0] mg_addr,
	input wire logic [15:0] mg_wdata,
	input wire logic mg_ack,
	// MAC streams and receive clock
	input wire logic [7:0] mac_txd,
	input wire logic mac_tx_en,
	input wire logic [7:0] mac_rxd,
	input wire logic mac_rx_dv,
	input wire logic rx_clk
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!arst_n_in);
	logic [15:0] bc_ff; // Shadow of basic control
	logic [15:0] msc_ff; // Shadow of master/slave control
	logic take; // Device accepts a write at this edge
	logic near; // Near loop set with AN off and full duplex
	logic gig; // Forced gigabit speed code
	assign take = mg_req & mg_we & ~mg_ack;
	assign near = bc_ff[`PLB_BC_LOOP] & bc_ff[`PLB_BC_FD] & ~bc_ff[`PLB_BC_AN];
	assign gig = bc_ff[`PLB_BC_SPD_MSB] & ~bc_ff[`PLB_BC_SPD_LSB];
	// Shadows follow only writes the device takes, so a refused
	// request during ack cannot corrupt them
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			bc_ff <= `PLB_BC_RST;
			msc_ff <= `PLB_MSC_RST;
		end else if (take && !mg_mmd) begin
			if (mg_addr == `PLB_REG_BC) bc_ff <= mg_wdata;
			if (mg_addr == `PLB_REG_MSC) msc_ff <= mg_wdata;
		end
	end
	property p_ack;
		take |=> mg_ack ##1 !mg_ack;
	endproperty
	a_ack: assert property (p_ack) else $error("ack not one cycle");
	property p_mmd;
		take && mg_mmd |-> mg_dev == `PLB_MMD_DEV && mg_wdata == `PLB_MMD_LOOP;
	endproperty
	a_mmd: assert property (p_mmd) else $error("bad tuning write");
	property p_bc;
		take && !mg_mmd && mg_addr == `PLB_REG_BC &&
			mg_wdata[`PLB_BC_LOOP]
			|-> !mg_wdata[`PLB_BC_AN] && mg_wdata[`PLB_BC_FD];
	endproperty
	a_bc: assert property (p_bc) else $error("near without AN off");
	property p_slave;
		take && !mg_mmd && mg_addr == `PLB_REG_MSC && bc_ff[`PLB_BC_LOOP]
			|-> mg_wdata == `PLB_MSC_SLAVE;
	endproperty
	a_slave: assert property (p_slave) else $error("near not slave");
	property p_ext;
		take && !mg_mmd && mg_addr == `PLB_REG_XLB &&
			mg_wdata[`PLB_XLB_EN]
			&& bc_ff == `PLB_BC_G1000 |-> msc_ff == `PLB_MSC_MASTER;
	endproperty
	a_ext: assert property (p_ext) else $error("ext order wrong");
	property p_near_dv;
		$past(near) |-> mac_rx_dv == $past(mac_tx_en);
	endproperty
	a_near_dv: assert property (p_near_dv) else $error("near dv");
	property p_near_g;
		$past(near && gig && mac_tx_en) |-> mac_rxd == $past(mac_txd);
	endproperty
	a_near_g: assert property (p_near_g) else $error("near gig data");
	property p_near_m;
		$past(near && !gig && mac_tx_en)
			|-> mac_rxd == ($past(mac_txd) & `PLB_MASK_MII);
	endproperty
	a_near_m: assert property (p_near_m) else $error("near mii data");
	property p_rxc;
		$changed(rx_clk) |-> $past(rx_clk, RXC_HALF) == $past(rx_clk);
	endproperty
	a_rxc: assert property (p_rxc) else $error("rx clock fast");
endmodule

// file: test/phy_loopback_control_tb_top.sv
/*
 Bench: software drives the manager over APB, one byte is sent on
 the user and line streams, and device outputs are compared.
 Assumes a single 125 MHz clock for both ends.
*/
`timescale 1ns/10ps
`include "plb_map.svh"
module phy_loopback_control_tb_top import plb_pkg::*;;
	localparam logic [3:0] RXH = `PLB_RXC_HALF;
	logic clock_in = 1'b0, arst_n_in = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err;
	logic [7:0] utxd = 8'h00, lrxd = 8'h00, urxd, ltxd, m;
	logic utxen = 1'b0, lrxdv = 1'b0, urxdv, ltxen;
	logic an_full = 1'b1, fd, an_en, role, near, far, ext;
	logic [1:0] an_spd = 2'b10, spd;
	logic [8:0] lt1, lt2, ur2, ur3; // Captured {valid, data}
	int fail_count = 0, n_tests = 0;
	plb_if lb();
	always #4 clock_in = ~clock_in;
	plb_mgr i_plb_mgr (.clock_in(clock_in), .arst_n_in(arst_n_in),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
		.paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .user_txd_in(utxd),
		.user_tx_en_in(utxen), .user_tx_er_in(1'b0), .user_rxd_out(urxd),
		.user_rx_dv_out(urxdv), .user_rx_er_out(), .bus(lb.mgr));
	plb_phy #(.RXC_HALF(RXH)) i_plb_phy (.clock_in(clock_in),
		.arst_n_in(arst_n_in), .bus(lb.phy), .line_rxd_in(lrxd),
		.line_rx_dv_in(lrxdv), .line_rx_er_in(1'b0), .an_done_in(1'b1),
		.an_speed_in(an_spd), .an_full_in(an_full), .line_txd_out(ltxd),
		.line_tx_en_out(ltxen), .line_tx_er_out(), .speed_out(spd),
		.full_duplex_out(fd), .an_enable_out(an_en), .role_master_out(role),
		.near_active_out(near), .far_active_out(far), .ext_active_out(ext));
	plb_loop_asserts #(.RXC_HALF(RXH)) i_plb_loop_asserts (
		.clock_in(clock_in), .arst_n_in(arst_n_in), .mg_req(lb.mg_req),
		.mg_we(lb.mg_we), .mg_mmd(lb.mg_mmd), .mg_dev(lb.mg_dev),
		.mg_addr(lb.mg_addr), .mg_wdata(lb.mg_wdata), .mg_ack(lb.mg_ack),
		.mac_txd(lb.mac_txd), .mac_tx_en(lb.mac_tx_en),
		.mac_rxd(lb.mac_rxd), .mac_rx_dv(lb.mac_rx_dv), .rx_clk(lb.rx_clk));
	// Count a comparison and report a mismatch at once
	task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", nm, exp, got);
		end
	endtask
	// One APB transfer; an idle cycle first leaves psel low between transfers
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock_in);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock_in);
		penable <= 1'b1;
		// Wait for the answer; only the watchdog ends a hang here
		do begin
			@(posedge clock_in);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Start a sequence, then poll the sticky done flag
	task go(input logic [7:0] c);
		int k;
		apb(1'b1, `PLB_APB_CTRL, {23'h0, 1'b1, c});
		k = 0;
		do begin
			apb(1'b0, `PLB_APB_STAT, 32'h0);
			k++;
		end while (rd[2] !== 1'b1 && k < 60);
		chk("done", 16'h1, {15'h0, rd[2]});
	endtask
	// One-cycle byte on both streams; outputs caught at fixed delays
	task xfer(input logic [7:0] t, input logic [7:0] l);
		@(posedge clock_in);
		utxd <= t;
		utxen <= 1'b1;
		lrxd <= l;
		lrxdv <= 1'b1;
		@(posedge clock_in);
		utxen <= 1'b0;
		lrxdv <= 1'b0;
		#1 lt1 = {ltxen, ltxd};
		@(posedge clock_in);
		#1 lt2 = {ltxen, ltxd};
		ur2 = {urxdv, urxd};
		@(posedge clock_in);
		#1 ur3 = {urxdv, urxd};
	endtask
	// Verdict and end of run
	task wrap_up();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Hang guard, far beyond the few hundred cycles needed
	initial begin
		repeat (20000) @(posedge clock_in);
		fail_count++;
		wrap_up();
	end
	initial begin
		repeat (10) @(posedge clock_in);
		arst_n_in <= 1'b1;
		@(posedge clock_in);
		chk("an_en", 1, an_en);
		chk("speed", PLB_SPD_1000, spd);
		chk("paths", 0, {role, near, far, ext});
		apb(1'b0, 12'h008, 32'h0);
		chk("slverr", 1, err);
		chk("rdata", 0, rd[15:0]);
		// Near loop at each speed: MII keeps the low nibble only
		for (int s = 0; s < 3; s++) begin
			m = (s == 2) ? `PLB_MASK_GMII : `PLB_MASK_MII;
			go({4'h0, s[1:0], PLB_MODE_NEAR});
			chk("near", 1, near);
			chk("speed", s, spd);
			chk("fd_an", 2'b10, {fd, an_en});
			chk("role", 0, role);
			chk("stat", (s == 2) ? 16'h0504 : 16'h0404, rd[15:0]);
			xfer(8'hA5, 8'h3C);
			chk("near_rx", {1'b1, 8'hA5 & m}, ur3);
			chk("line_idle", 0, lt2);
		end
		// Far loop with forced gigabit; rx clock fed back needs time
		go({4'h0, PLB_SPD_1000, PLB_MODE_FAR});
		repeat (20) @(posedge clock_in);
		chk("far", 1, far);
		xfer(8'h11, 8'hC3);
		chk("far_line", {1'b1, 8'hC3}, lt1);
		chk("far_mac", {1'b1, 8'hC3}, ur2);
		go(PLB_MODE_NONE);
		chk("none", 0, {near, far, ext, ~an_en});
		// Far loop after negotiation: only gigabit full duplex counts
		an_spd <= 2'b01;
		go({4'h1, PLB_SPD_1000, PLB_MODE_FAR});
		repeat (20) @(posedge clock_in);
		chk("far_100", 0, far);
		an_spd <= 2'b10;
		an_full <= 1'b0;
		repeat (4) @(posedge clock_in);
		chk("far_half", 0, far);
		an_full <= 1'b1;
		repeat (4) @(posedge clock_in);
		chk("far_an", 1, far);
		go(PLB_MODE_NONE);
		// Connector loop, gigabit then 100: normal path both ways
		for (int s = 2; s > 0; s--) begin
			m = (s == 2) ? `PLB_MASK_GMII : `PLB_MASK_MII;
			go({4'h0, s[1:0], PLB_MODE_EXT});
			chk("ext", 3'b001, {near, far, ext});
			chk("speed", s, spd);
			chk("role", 1, role);
			xfer(8'h5A, 8'h96);
			chk("ext_tx", {1'b1, 8'h5A & m}, lt2);
			chk("ext_rx", {1'b1, 8'h96 & m}, ur2);
		end
		wrap_up();
	end
endmodule
